// >>> pkg/tpc_pkg.sv
// constants and types shared by the timer channel mode logic
package tpc_pkg;
    // register offsets
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_VALUE_HI = 8'h01;
    localparam logic [7:0] OFS_VALUE_LO = 8'h02;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h03;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
    // channel_status_control fields
    localparam int SC_FLAG_BIT = 7;
    localparam int SC_IE_BIT = 6;
    localparam int SC_MS_HI_BIT = 5;
    localparam int SC_MS_LO_BIT = 4;
    localparam int SC_ELS_HI_BIT = 3;
    localparam int SC_ELS_LO_BIT = 2;
    localparam logic [7:0] SC_WRITE_MASK = 8'h7C;
    localparam logic [7:0] SC_RESET = 8'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    // irq status bits
    localparam int IRQ_CAPTURE_BIT = 0;
    localparam int IRQ_MATCH_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // edge/level encodings
    localparam logic [1:0] ELS_NONE = 2'h0;
    localparam logic [1:0] ELS_RISE = 2'h1;
    localparam logic [1:0] ELS_FALL = 2'h2;
    localparam logic [1:0] ELS_BOTH = 2'h3;
    localparam logic [1:0] MS_CAPTURE = 2'h0;
    localparam logic [1:0] MS_COMPARE = 2'h1;

    typedef enum logic [2:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EDGE_PWM,
        MODE_CENTER_PWM
    } tpc_mode_e;

    // counter view supplied by the shared timer core
    typedef struct packed {
        logic [15:0] value;
        logic [15:0] modulo;
        logic up;
        logic tick;
        logic wrap;
    } tpc_cnt_s;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tpc_bus_s;
endpackage

// >>> rtl/tpc_channel.sv
// one timer/pwm channel: mode decode, capture, compare, pwm and registers
//
// Function
// - edge/level bits 00 release the pin whatever the mode bits say.
// - center select 0, mode 00, edge/level 01 captures on rising edges only.
// - capture with edge/level 10 captures on falling edges only.
// - capture with edge/level 11 captures on both edges.
// - center select 0, mode 01, edge/level 00 compares in software and uses no pin.
// - compare with edge/level 01 toggles the pin on each match.
// - compare with edge/level 10 drives the pin low on match.
// - compare with edge/level 11 drives the pin high on match.
// - mode 1X is edge-aligned pwm, edge/level 10 clears the pin on match.
// - edge-aligned pwm with edge/level X1 sets the pin on match.
// - center select 1 ignores mode bits, edge/level 10 clears on an up-count match.
// - center-aligned pwm with edge/level X1 sets the pin on an up-count match.
// - the channel flag sets on an active capture edge or on a compare or pwm match.
// - pwm at 0 or 100 percent duty never sets the channel flag.
// - an active capture edge loads the counter value into the channel value.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tpc_channel (
    input wire logic mclk,
    input wire logic rst_b,
    input wire tpc_pkg::tpc_bus_s bus,
    output logic [7:0] rdata,
    input wire tpc_pkg::tpc_cnt_s cnt,
    input wire logic center_aligned_select,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_b,
    output logic channel_irq,
    output logic irq
);
    logic [7:0] channel_status_control;
    logic [15:0] channel_value;
    logic [tpc_pkg::IRQ_W-1:0] irq_status;
    logic [tpc_pkg::IRQ_W-1:0] irq_mask;
    logic clear_armed;
    logic edge_rise;
    logic edge_fall;

    logic channel_flag;
    logic mode_select_hi;
    logic mode_select_lo;
    logic edge_level_select_hi;
    logic edge_level_select_lo;
    logic [1:0] els;
    logic [1:0] ms;
    tpc_pkg::tpc_mode_e mode;
    logic cap_evt;
    logic match;
    logic pwm_extreme;
    logic flag_evt;
    logic pin_drive;
    logic next_pin_out;
    localparam logic [15:0] VALUE_ZERO = tpc_pkg::VALUE_RESET;

    assign channel_flag = channel_status_control[tpc_pkg::SC_FLAG_BIT];
    assign mode_select_hi = channel_status_control[tpc_pkg::SC_MS_HI_BIT];
    assign mode_select_lo = channel_status_control[tpc_pkg::SC_MS_LO_BIT];
    assign edge_level_select_hi = channel_status_control[tpc_pkg::SC_ELS_HI_BIT];
    assign edge_level_select_lo = channel_status_control[tpc_pkg::SC_ELS_LO_BIT];
    assign els = {edge_level_select_hi, edge_level_select_lo};
    assign ms = {mode_select_hi, mode_select_lo};

    tpc_edge_detect u_edge (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin(pin_in),
        .rise(edge_rise),
        .fall(edge_fall)
    );

    // mode decode
    always_comb begin
        if (center_aligned_select) begin
            mode = tpc_pkg::MODE_CENTER_PWM;
        end else if (mode_select_hi) begin
            mode = tpc_pkg::MODE_EDGE_PWM;
        end else if (ms == tpc_pkg::MS_COMPARE) begin
            mode = tpc_pkg::MODE_COMPARE;
        end else begin
            mode = tpc_pkg::MODE_CAPTURE;
        end
    end

    // active capture edge
    always_comb begin
        cap_evt = 1'b0;
        if (mode == tpc_pkg::MODE_CAPTURE) begin
            case (els)
                tpc_pkg::ELS_RISE: cap_evt = edge_rise;
                tpc_pkg::ELS_FALL: cap_evt = edge_fall;
                tpc_pkg::ELS_BOTH: cap_evt = edge_rise | edge_fall;
                default: cap_evt = 1'b0;
            endcase
        end
    end

    assign match = cnt.tick && (cnt.value == channel_value) && (mode != tpc_pkg::MODE_CAPTURE);

    // 0 and 100 percent duty settings
    always_comb begin
        pwm_extreme = 1'b0;
        if (mode == tpc_pkg::MODE_EDGE_PWM) begin
            pwm_extreme = (channel_value == VALUE_ZERO) || (channel_value > cnt.modulo);
        end else if (mode == tpc_pkg::MODE_CENTER_PWM) begin
            pwm_extreme = (channel_value == VALUE_ZERO) || (channel_value >= cnt.modulo);
        end
    end

    assign flag_evt = cap_evt || (match && !pwm_extreme);

    // pin is driven in any non-capture mode unless edge/level is 00
    assign pin_drive = (els != tpc_pkg::ELS_NONE) && (mode != tpc_pkg::MODE_CAPTURE);

    always_comb begin
        next_pin_out = pin_out;
        case (mode)
            tpc_pkg::MODE_COMPARE: begin
                if (match) begin
                    case (els)
                        tpc_pkg::ELS_RISE: next_pin_out = ~pin_out;
                        tpc_pkg::ELS_FALL: next_pin_out = 1'b0;
                        tpc_pkg::ELS_BOTH: next_pin_out = 1'b1;
                        default: next_pin_out = pin_out;
                    endcase
                end
            end
            tpc_pkg::MODE_EDGE_PWM: begin
                // period start asserts the pulse, match ends it
                if (cnt.tick && cnt.wrap) begin
                    next_pin_out = ~edge_level_select_lo;
                end
                if (match) begin
                    next_pin_out = edge_level_select_lo;
                end
            end
            tpc_pkg::MODE_CENTER_PWM: begin
                if (match) begin
                    next_pin_out = cnt.up ? edge_level_select_lo : ~edge_level_select_lo;
                end
            end
            default: next_pin_out = pin_out;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= 1'b0;
            pin_oe_b <= 1'b1;
        end else begin
            pin_out <= next_pin_out;
            pin_oe_b <= ~pin_drive;
        end
    end

    // status and control register, flag clear needs read-then-write-0
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            channel_status_control <= tpc_pkg::SC_RESET;
            clear_armed <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == tpc_pkg::OFS_STATUS_CONTROL) begin
                channel_status_control[tpc_pkg::SC_IE_BIT:tpc_pkg::SC_ELS_LO_BIT] <=
                    bus.wdata[tpc_pkg::SC_IE_BIT:tpc_pkg::SC_ELS_LO_BIT];
                clear_armed <= 1'b0;
                if (clear_armed && !bus.wdata[tpc_pkg::SC_FLAG_BIT] && !flag_evt) begin
                    channel_status_control[tpc_pkg::SC_FLAG_BIT] <= 1'b0;
                end
            end else if (bus.rd && bus.addr == tpc_pkg::OFS_STATUS_CONTROL && channel_flag) begin
                clear_armed <= 1'b1;
            end
            if (flag_evt) begin
                channel_status_control[tpc_pkg::SC_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // channel value: capture load, or byte writes outside capture mode
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            channel_value <= tpc_pkg::VALUE_RESET;
        end else if (cap_evt) begin
            channel_value <= cnt.value;
        end else if (bus.wr && mode != tpc_pkg::MODE_CAPTURE) begin
            if (bus.addr == tpc_pkg::OFS_VALUE_HI) begin
                channel_value[15:8] <= bus.wdata;
            end else if (bus.addr == tpc_pkg::OFS_VALUE_LO) begin
                channel_value[7:0] <= bus.wdata;
            end
        end
    end

    // sticky event status, cleared by reading it; a new event wins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= tpc_pkg::IRQ_RESET;
            irq_mask <= tpc_pkg::IRQ_RESET;
        end else begin
            if (bus.rd && bus.addr == tpc_pkg::OFS_IRQ_STATUS) begin
                irq_status <= {match && !pwm_extreme, cap_evt};
            end else begin
                irq_status <= irq_status | {match && !pwm_extreme, cap_evt};
            end
            if (bus.wr && bus.addr == tpc_pkg::OFS_IRQ_MASK) begin
                irq_mask <= bus.wdata[tpc_pkg::IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
            channel_irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
            channel_irq <= channel_flag & channel_status_control[tpc_pkg::SC_IE_BIT];
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (!bus.rd) begin
            rdata <= 8'h00;
        end else if (bus.addr == tpc_pkg::OFS_STATUS_CONTROL) begin
            rdata <= channel_status_control & ~8'h03;
        end else if (bus.addr == tpc_pkg::OFS_VALUE_HI) begin
            rdata <= channel_value[15:8];
        end else if (bus.addr == tpc_pkg::OFS_VALUE_LO) begin
            rdata <= channel_value[7:0];
        end else if (bus.addr == tpc_pkg::OFS_IRQ_STATUS) begin
            rdata <= {6'h00, irq_status};
        end else if (bus.addr == tpc_pkg::OFS_IRQ_MASK) begin
            rdata <= {6'h00, irq_mask};
        end else begin
            rdata <= 8'h00;
        end
    end

    // checks
    pin_released_a: assert property (@(posedge mclk) disable iff (!rst_b)
        els == tpc_pkg::ELS_NONE |=> pin_oe_b)
        else $error("pin driven with edge/level 00");

    rise_capture_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (!center_aligned_select && ms == tpc_pkg::MS_CAPTURE && els == tpc_pkg::ELS_RISE
         && edge_rise) |=> (channel_value == $past(cnt.value)) && channel_flag)
        else $error("rising edge not captured");

    fall_only_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == tpc_pkg::MODE_CAPTURE && els == tpc_pkg::ELS_FALL && edge_rise
         && !channel_flag) |=> !channel_flag)
        else $error("falling edge select wrong");

    both_edges_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == tpc_pkg::MODE_CAPTURE && els == tpc_pkg::ELS_BOTH && (edge_rise || edge_fall))
        |=> channel_flag)
        else $error("edge missed with both edges selected");

    sw_compare_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == tpc_pkg::MODE_COMPARE && els == tpc_pkg::ELS_NONE && match)
        |=> pin_oe_b && channel_flag)
        else $error("software compare misbehaved");

    oc_toggle_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == tpc_pkg::MODE_COMPARE && els == tpc_pkg::ELS_RISE && match)
        |=> pin_out != $past(pin_out))
        else $error("toggle on match missing");

    oc_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == tpc_pkg::MODE_COMPARE && els == tpc_pkg::ELS_FALL && match) |=> !pin_out)
        else $error("clear on match missing");

    oc_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == tpc_pkg::MODE_COMPARE && els == tpc_pkg::ELS_BOTH && match) |=> pin_out)
        else $error("set on match missing");

    epwm_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == tpc_pkg::MODE_EDGE_PWM && els == tpc_pkg::ELS_FALL && match) |=> !pin_out)
        else $error("edge pwm high-true not cleared");

    epwm_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == tpc_pkg::MODE_EDGE_PWM && edge_level_select_lo && match) |=> pin_out)
        else $error("edge pwm low-true not set");

    cpwm_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (center_aligned_select && els == tpc_pkg::ELS_FALL && match && cnt.up) |=> !pin_out)
        else $error("center pwm high-true not cleared");

    cpwm_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (center_aligned_select && edge_level_select_lo && match && cnt.up) |=> pin_out)
        else $error("center pwm low-true not set");

    flag_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
        flag_evt |=> channel_flag)
        else $error("channel flag not set");

    duty_extreme_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (!channel_flag && match && pwm_extreme && !cap_evt) |=> !channel_flag)
        else $error("flag set at 0 or 100 percent duty");

    capture_load_a: assert property (@(posedge mclk) disable iff (!rst_b)
        cap_evt |=> channel_value == $past(cnt.value))
        else $error("capture did not load counter");

    low_bits_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(bus.rd) && $past(bus.addr) == tpc_pkg::OFS_STATUS_CONTROL |-> rdata[1:0] == 2'h0)
        else $error("reserved bits read nonzero");

    low_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
        channel_status_control[1:0] == 2'h0)
        else $error("reserved status bits set");

    capture_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == tpc_pkg::MODE_CAPTURE && !cap_evt) |=> $stable(channel_value))
        else $error("channel value changed without capture");

    capture_pin_a: assert property (@(posedge mclk) disable iff (!rst_b)
        mode == tpc_pkg::MODE_CAPTURE |=> pin_oe_b)
        else $error("pin driven in capture mode");

    match_sticky_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (match && !pwm_extreme) |=> irq_status[tpc_pkg::IRQ_MATCH_BIT])
        else $error("match event lost in status");

    zero_duty_a: assert property (@(posedge mclk) disable iff (!rst_b)
        ((mode == tpc_pkg::MODE_EDGE_PWM || mode == tpc_pkg::MODE_CENTER_PWM) && match
         && channel_value == VALUE_ZERO && !channel_flag) |=> !channel_flag)
        else $error("flag set at 0 percent duty");

    capture_seen_c: cover property (@(posedge mclk) disable iff (!rst_b) cap_evt);
    epwm_match_c: cover property (@(posedge mclk) disable iff (!rst_b)
        mode == tpc_pkg::MODE_EDGE_PWM && match && !pwm_extreme);
    cpwm_down_c: cover property (@(posedge mclk) disable iff (!rst_b)
        mode == tpc_pkg::MODE_CENTER_PWM && match && !cnt.up);
    flag_cleared_c: cover property (@(posedge mclk) disable iff (!rst_b)
        channel_flag ##1 !channel_flag);
    toggle_match_c: cover property (@(posedge mclk) disable iff (!rst_b)
        mode == tpc_pkg::MODE_COMPARE && els == tpc_pkg::ELS_RISE && match);
endmodule
`default_nettype wire

// >>> rtl/tpc_edge_detect.sv
// registered rising and falling edge pulses of the channel input
`timescale 1ns/1ns
`default_nettype none
module tpc_edge_detect (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic prev;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            prev <= pin;
            rise <= pin & ~prev;
            fall <= ~pin & prev;
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb_timer_channel_mode_edge_select.sv
// self-checking bench for the timer channel mode and edge selection
`timescale 1ns/1ns
`default_nettype none
module tb_timer_channel_mode_edge_select;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    tpc_pkg::tpc_bus_s bus = '0;
    tpc_pkg::tpc_cnt_s cnt = '0;
    logic center_aligned_select = 1'b0;
    logic gpio_level = 1'b0;
    logic pin_wire;
    logic [7:0] rdata;
    logic pin_out;
    logic pin_oe_b;
    logic channel_irq;
    logic irq;
    logic [7:0] rd_val;
    logic [15:0] exp_v;
    logic p0;
    int miscompares = 0;
    int n_checks = 0;

    tpc_channel dut (.mclk(mclk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .cnt(cnt),
        .center_aligned_select(center_aligned_select), .pin_in(pin_wire), .pin_out(pin_out),
        .pin_oe_b(pin_oe_b), .channel_irq(channel_irq), .irq(irq));
    tpc_pin_model u_pin (.pin_out(pin_out), .pin_oe_b(pin_oe_b), .gpio_level(gpio_level),
        .pin_wire(pin_wire));

    initial begin
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bw(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '0;
    endtask

    task automatic br(input logic [7:0] a);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '0;
        #1;
        rd_val = rdata;
    endtask

    // read arms the flag clear, the write of sc with bit 7 low completes it
    task automatic arm_clear(input logic [7:0] sc);
        br(tpc_pkg::OFS_STATUS_CONTROL);
        bw(tpc_pkg::OFS_STATUS_CONTROL, sc);
    endtask

    task automatic setup(input logic [7:0] sc, input logic [15:0] v);
        bw(tpc_pkg::OFS_STATUS_CONTROL, sc);
        bw(tpc_pkg::OFS_VALUE_HI, v[15:8]);
        bw(tpc_pkg::OFS_VALUE_LO, v[7:0]);
        arm_clear(sc);
    endtask

    task automatic step(input logic [15:0] v, input logic up, input logic wrap);
        @(posedge mclk);
        cnt <= '{value: v, modulo: 16'h0010, up: up, tick: 1'b1, wrap: wrap};
        @(posedge mclk);
        cnt.tick <= 1'b0;
        cnt.wrap <= 1'b0;
        #1;
    endtask

    task automatic flag_is(input logic f);
        br(tpc_pkg::OFS_STATUS_CONTROL);
        chk(rd_val[7], f);
    endtask

    task automatic t_regs;
        br(tpc_pkg::OFS_STATUS_CONTROL);
        chk(rd_val, 8'h00);
        br(tpc_pkg::OFS_VALUE_LO);
        chk(rd_val, 8'h00);
        bw(8'h3F, 8'hAA);
        br(8'h3F);
        chk(rd_val, 8'h00);
        chk(pin_oe_b, 1'b1);
        bw(tpc_pkg::OFS_STATUS_CONTROL, 8'hFF);
        br(tpc_pkg::OFS_STATUS_CONTROL);
        chk(rd_val, 8'h7C);
        chk(pin_oe_b, 1'b0);
        bw(tpc_pkg::OFS_STATUS_CONTROL, 8'h30);
        repeat (2) @(posedge mclk);
        #1;
        chk(pin_oe_b, 1'b1);
        $display("test regs done");
    endtask

    task automatic t_capture;
        exp_v = 16'h0000;
        for (int e = 1; e < 4; e++) begin
            bw(tpc_pkg::OFS_STATUS_CONTROL, {4'h0, e[1:0], 2'b00});
            repeat (3) @(posedge mclk);
            arm_clear({4'h0, e[1:0], 2'b00});
            @(posedge mclk);
            cnt.value <= 16'h1100 + 16'(e);
            gpio_level <= 1'b1;
            repeat (4) @(posedge mclk);
            flag_is(e[0]);
            if (e[0]) exp_v = 16'h1100 + 16'(e);
            br(tpc_pkg::OFS_VALUE_HI);
            chk(rd_val, exp_v[15:8]);
            arm_clear({4'h0, e[1:0], 2'b00});
            @(posedge mclk);
            cnt.value <= 16'h2200 + 16'(e);
            gpio_level <= 1'b0;
            repeat (4) @(posedge mclk);
            flag_is(e[1]);
            if (e[1]) exp_v = 16'h2200 + 16'(e);
            br(tpc_pkg::OFS_VALUE_LO);
            chk(rd_val, exp_v[7:0]);
        end
        $display("test capture done");
    endtask

    task automatic t_compare;
        setup(8'h14, 16'h0010);
        p0 = pin_out;
        step(16'h0010, 1'b1, 1'b0);
        chk(pin_out, !p0);
        chk(pin_oe_b, 1'b0);
        step(16'h0011, 1'b1, 1'b0);
        chk(pin_out, !p0);
        step(16'h0010, 1'b1, 1'b0);
        chk(pin_out, p0);
        flag_is(1'b1);
        bw(tpc_pkg::OFS_STATUS_CONTROL, 8'h1C);
        step(16'h0010, 1'b1, 1'b0);
        chk(pin_out, 1'b1);
        bw(tpc_pkg::OFS_STATUS_CONTROL, 8'h18);
        step(16'h0010, 1'b1, 1'b0);
        chk(pin_out, 1'b0);
        arm_clear(8'h10);
        repeat (2) @(posedge mclk);
        #1;
        chk(pin_oe_b, 1'b1);
        step(16'h0010, 1'b1, 1'b0);
        flag_is(1'b1);
        $display("test compare done");
    endtask

    task automatic t_irq;
        setup(8'h54, 16'h0010);
        bw(tpc_pkg::OFS_IRQ_MASK, 8'h02);
        br(tpc_pkg::OFS_IRQ_STATUS);
        step(16'h0010, 1'b1, 1'b0);
        @(posedge mclk);
        #1;
        chk(irq, 1'b1);
        chk(channel_irq, 1'b1);
        br(tpc_pkg::OFS_IRQ_STATUS);
        chk(rd_val, 8'h02);
        @(posedge mclk);
        #1;
        chk(irq, 1'b0);
        bw(tpc_pkg::OFS_STATUS_CONTROL, 8'h54);
        repeat (2) @(posedge mclk);
        #1;
        chk(channel_irq, 1'b1);
        arm_clear(8'h54);
        repeat (2) @(posedge mclk);
        #1;
        chk(channel_irq, 1'b0);
        bw(tpc_pkg::OFS_IRQ_MASK, 8'h00);
        step(16'h0010, 1'b1, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
        chk(irq, 1'b0);
        br(tpc_pkg::OFS_IRQ_STATUS);
        chk(rd_val, 8'h02);
        $display("test irq done");
    endtask

    task automatic t_edge_pwm;
        setup(8'h28, 16'h0005);
        step(16'h0000, 1'b1, 1'b1);
        chk(pin_out, 1'b1);
        step(16'h0005, 1'b1, 1'b0);
        chk(pin_out, 1'b0);
        flag_is(1'b1);
        for (int i = 0; i < 2; i++) begin
            setup(i ? 8'h3C : 8'h24, 16'h0005);
            step(16'h0000, 1'b1, 1'b1);
            chk(pin_out, 1'b0);
            step(16'h0005, 1'b1, 1'b0);
            chk(pin_out, 1'b1);
        end
        for (int i = 0; i < 2; i++) begin
            setup(8'h28, i ? 16'h0011 : 16'h0000);
            step(i ? 16'h0011 : 16'h0000, 1'b1, 1'b0);
            flag_is(1'b0);
        end
        $display("test edge pwm done");
    endtask

    task automatic t_center;
        @(posedge mclk);
        center_aligned_select <= 1'b1;
        setup(8'h38, 16'h0005);
        step(16'h0005, 1'b0, 1'b0);
        step(16'h0005, 1'b1, 1'b0);
        chk(pin_out, 1'b0);
        flag_is(1'b1);
        setup(8'h04, 16'h0005);
        step(16'h0005, 1'b0, 1'b0);
        step(16'h0005, 1'b1, 1'b0);
        chk(pin_out, 1'b1);
        setup(8'h08, 16'h0010);
        step(16'h0010, 1'b1, 1'b0);
        flag_is(1'b0);
        @(posedge mclk);
        center_aligned_select <= 1'b0;
        $display("test center pwm done");
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        give_verdict;
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs;
        t_capture;
        t_compare;
        t_irq;
        t_edge_pwm;
        t_center;
        give_verdict;
    end
endmodule
`default_nettype wire

// >>> sim/tpc_pin_model.sv
// external pin: gpio logic owns the line whenever the channel releases it
`timescale 1ns/1ns
`default_nettype none
module tpc_pin_model (
    input wire logic pin_out,
    input wire logic pin_oe_b,
    input wire logic gpio_level,
    output logic pin_wire
);
    assign pin_wire = pin_oe_b ? gpio_level : pin_out;
endmodule
`default_nettype wire
